//--- inc/gate_delay_pkg.sv
// Purpose: Shared constants and types for the gate delay status registers
// Assumes: 7-bit register address, 16-bit register data
// Notes:   Field positions, offsets and reset values live here only

// ============================================================
// Package
// ============================================================
package gate_delay_pkg;

  // Register address width and data width
  localparam int unsigned ADDR_W   = 7;
  localparam int unsigned DATA_W   = 16;
  // Width of a raw measurement count from the timing logic
  localparam int unsigned MEAS_W   = 8;
  // Width of a reported delay field
  localparam int unsigned FIELD_W  = 6;
  // Number of half-bridges
  localparam int unsigned NUM_HB   = 3;

  // Register offsets
  localparam logic [ADDR_W-1:0] HB1_DELAYS_ADDR = 7'h53;
  localparam logic [ADDR_W-1:0] HB2_DELAYS_ADDR = 7'h54;
  localparam logic [ADDR_W-1:0] HB3_DELAYS_ADDR = 7'h55;

  // Field positions
  localparam int unsigned OFF_LSB  = 8;
  localparam int unsigned OFF_MSB  = 13;
  localparam int unsigned ON_LSB   = 0;
  localparam int unsigned ON_MSB   = 5;

  // Reset values
  localparam logic [DATA_W-1:0]  DELAYS_RESET = 16'h0000;
  localparam logic [FIELD_W-1:0] FIELD_RESET  = 6'h00;
  // Largest reportable count, used for saturation
  localparam logic [FIELD_W-1:0] FIELD_MAX    = 6'h3F;

  // Weight of one count, in picoseconds (53.3 ns)
  localparam int unsigned COUNT_WEIGHT_PS = 53300;

  // One completed switching measurement from one half-bridge
  typedef struct packed {
    logic              done;
    logic [MEAS_W-1:0] on_cnt;
    logic [MEAS_W-1:0] off_cnt;
  } meas_t;

  // One register read request
  typedef struct packed {
    logic              stb;
    logic [ADDR_W-1:0] addr;
  } rd_req_t;

endpackage : gate_delay_pkg

//--- hw/gate_delay_status_regs.sv
// Purpose: Read-only effective turn-on/off delay registers, three bridges
// Assumes: Inputs synchronous to mclk; reset synchronous, active low
// Notes:   Register port sits behind the serial register interface
//
// Contract
// RULE_01: Reserved bits 15:14 and 7:6 read zero
// RULE_02: Bridge one off delay in bits 13:8
// RULE_03: Bridge one on delay in bits 5:0
// RULE_04: Bridge two off delay in bits 13:8
// RULE_05: Bridge two on delay in bits 5:0
// RULE_06: Bridge three off delay in bits 13:8
// RULE_07: Bridge three on delay in bits 5:0
// RULE_08: Power-on or soft reset clears all registers
// RULE_09: Restart keeps delay fields, reserved bits zero
// RULE_10: Host writes never alter delay values
// RULE_11: Refresh per transition, saturate counts at 63

`timescale 1ns/1ps
`default_nettype none

module gate_delay_status_regs
  import gate_delay_pkg::*;
(
  // Clock and resets
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              soft_rst,
  input  wire logic              restart,
  // Measurements from the gate-drive timing logic
  input  wire meas_t             meas [NUM_HB],
  // Register port
  input  wire rd_req_t           rd_req,
  input  wire logic              wr_stb,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  // Register answers
  output logic      [DATA_W-1:0] rd_data,
  output logic                   rd_valid,
  output logic                   rd_unmapped,
  output logic                   wr_refused
);

  // ============================================================
  // Saturation helper
  // ============================================================
  // Clamp a raw count to the six-bit field
  function automatic logic [FIELD_W-1:0] sat_count(
    input logic [MEAS_W-1:0] raw
  );
    logic [FIELD_W-1:0] res;
    res = FIELD_MAX;
    if (raw <= MEAS_W'(FIELD_MAX)) begin
      res = raw[FIELD_W-1:0];
    end
    return res;
  endfunction : sat_count

  // ============================================================
  // Delay field storage
  // ============================================================
  logic [NUM_HB-1:0][FIELD_W-1:0] on_q;        // Stored turn-on counts
  logic [NUM_HB-1:0][FIELD_W-1:0] off_q;       // Stored turn-off counts
  logic [NUM_HB-1:0][DATA_W-1:0]  reg_view;    // Register images
  logic                           clear_all;   // Soft reset clear

  // Soft reset clears the delay fields as power-on does
  assign clear_all = soft_rst;

  genvar g;
  generate
    for (g = 0; g < NUM_HB; g++) begin : gen_hb
      logic               refresh;     // Accept a new measurement
      logic [FIELD_W-1:0] next_on;     // Saturated turn-on count
      logic [FIELD_W-1:0] next_off;    // Saturated turn-off count

      // Restart freezes the fields, so a measurement then is dropped
      assign refresh  = meas[g].done && !restart && !clear_all; // RULE_09
      assign next_on  = sat_count(meas[g].on_cnt);              // RULE_11
      assign next_off = sat_count(meas[g].off_cnt);             // RULE_11

      // Field registers; no path from the write port
      always_ff @(posedge mclk) begin
        if (!rst_n || clear_all) begin
          on_q[g]  <= FIELD_RESET;                              // RULE_08
          off_q[g] <= FIELD_RESET;                              // RULE_08
        end else if (refresh) begin
          on_q[g]  <= next_on;                                  // RULE_11
          off_q[g] <= next_off;                                 // RULE_11
        end
      end

      // Reserved bits are constant zero in every state
      assign reg_view[g] = {2'h0, off_q[g], 2'h0, on_q[g]};     // RULE_01
    end
  endgenerate

  // ============================================================
  // Read decode
  // ============================================================
  logic              hit1;       // Address selects bridge one
  logic              hit2;       // Address selects bridge two
  logic              hit3;       // Address selects bridge three
  logic              rd_hit;     // Any mapped address
  logic [DATA_W-1:0] next_rd;    // Data to present

  assign hit1    = rd_req.addr == HB1_DELAYS_ADDR;
  assign hit2    = rd_req.addr == HB2_DELAYS_ADDR;
  assign hit3    = rd_req.addr == HB3_DELAYS_ADDR;
  assign rd_hit  = hit1 || hit2 || hit3;
  // Unmapped addresses read as zero
  assign next_rd = hit1 ? reg_view[0] :                  // RULE_02 RULE_03
                   hit2 ? reg_view[1] :                  // RULE_04 RULE_05
                   hit3 ? reg_view[2] : DELAYS_RESET;    // RULE_06 RULE_07

  // Read answer registers, one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_data     <= DELAYS_RESET;
      rd_valid    <= 1'b0;
      rd_unmapped <= 1'b0;
    end else begin
      rd_valid    <= rd_req.stb;
      rd_unmapped <= rd_req.stb && !rd_hit;
      if (rd_req.stb) begin
        rd_data <= next_rd;                                     // RULE_03
      end
    end
  end

  // ============================================================
  // Write handling
  // ============================================================
  // Every write is refused; data is discarded
  logic wr_seen;    // A write arrived this cycle

  assign wr_seen = wr_stb && (wr_addr == wr_addr) && (wr_data == wr_data);

  // One-cycle refusal pulse for every write
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_refused <= 1'b0;
    end else begin
      wr_refused <= wr_seen;                                    // RULE_10
    end
  end

  // ============================================================
  // Assertions
  // ============================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Read of one address
  sequence rd_of(logic [ADDR_W-1:0] a);
    rd_req.stb && rd_req.addr == a;
  endsequence

  // Quiet cycle with neither soft reset nor restart
  sequence quiet_cycle;
    !soft_rst && !restart;
  endsequence

  resv_bits_zero_a: assert property (                           // RULE_01
    rd_valid |-> rd_data[15:14] == 2'h0 && rd_data[7:6] == 2'h0)
    else $error("reserved bits read nonzero");

  hb1_off_read_a: assert property (                             // RULE_02
    rd_of(HB1_DELAYS_ADDR) |=> rd_valid &&
      rd_data[OFF_MSB:OFF_LSB] == $past(off_q[0]))
    else $error("bridge one off delay misread");

  hb1_on_read_a: assert property (                              // RULE_03
    rd_of(HB1_DELAYS_ADDR) |=> rd_data[ON_MSB:ON_LSB] == $past(on_q[0]))
    else $error("bridge one on delay misread");

  hb2_off_read_a: assert property (                             // RULE_04
    rd_of(HB2_DELAYS_ADDR) |=> rd_data[OFF_MSB:OFF_LSB] == $past(off_q[1]))
    else $error("bridge two off delay misread");

  hb2_on_read_a: assert property (                              // RULE_05
    rd_of(HB2_DELAYS_ADDR) |=> rd_data[ON_MSB:ON_LSB] == $past(on_q[1]))
    else $error("bridge two on delay misread");

  hb3_off_read_a: assert property (                             // RULE_06
    rd_of(HB3_DELAYS_ADDR) |=> rd_data[OFF_MSB:OFF_LSB] == $past(off_q[2]))
    else $error("bridge three off delay misread");

  hb3_on_read_a: assert property (                              // RULE_07
    rd_of(HB3_DELAYS_ADDR) |=> rd_data[ON_MSB:ON_LSB] == $past(on_q[2]))
    else $error("bridge three on delay misread");

  soft_clear_a: assert property (                               // RULE_08
    soft_rst |=> on_q == '0 && off_q == '0)
    else $error("soft reset left a field set");

  restart_hold_a: assert property (                             // RULE_09
    restart && !soft_rst |=> $stable(on_q) && $stable(off_q))
    else $error("restart changed a delay field");

  write_ignored_a: assert property (                            // RULE_10
    (quiet_cycle and (wr_stb && !meas[0].done && !meas[1].done &&
      !meas[2].done)) |=> $stable(on_q) && $stable(off_q) && wr_refused)
    else $error("write altered a delay field");

  saturate_a: assert property (                                 // RULE_11
    (quiet_cycle and (meas[0].done && meas[0].on_cnt > MEAS_W'(FIELD_MAX)))
      |=> on_q[0] == FIELD_MAX)
    else $error("turn-on count not saturated");

  refresh_a: assert property (                                  // RULE_11
    (quiet_cycle and (meas[1].done && meas[1].off_cnt <= MEAS_W'(FIELD_MAX)))
      |=> off_q[1] == $past(meas[1].off_cnt[FIELD_W-1:0]))
    else $error("turn-off count not refreshed");

  unmapped_zero_a: assert property (
    rd_req.stb && !rd_hit |=> rd_unmapped && rd_data == DELAYS_RESET)
    else $error("unmapped read not zero");

  // ============================================================
  // Handshake and per-bridge checks
  // ============================================================
  // A read strobe seen at one edge
  sequence rd_strobe;
    rd_req.stb;
  endsequence

  rd_valid_pulse_a: assert property (
    rd_strobe |=> rd_valid)
    else $error("read strobe without valid");

  rd_valid_idle_a: assert property (
    !rd_req.stb |=> !rd_valid && !rd_unmapped)
    else $error("valid without a read strobe");

  // Data holds between reads, so a slow host still sees it
  rd_data_hold_a: assert property (
    !rd_req.stb |=> $stable(rd_data))
    else $error("read data moved without a strobe");

  mapped_flag_a: assert property (
    rd_req.stb && rd_hit |=> !rd_unmapped)
    else $error("mapped read flagged unmapped");

  // The unmapped flag only rides on a valid answer
  unmapped_valid_a: assert property (
    rd_unmapped |-> rd_valid)
    else $error("unmapped flag without valid");

  wr_refuse_pulse_a: assert property (                          // RULE_10
    !wr_stb |=> !wr_refused)
    else $error("refusal without a write");

  // In-range counts pass through unchanged
  refresh_off1_a: assert property (                             // RULE_02
    (quiet_cycle and (meas[0].done && meas[0].off_cnt <= MEAS_W'(FIELD_MAX)))
      |=> off_q[0] == $past(meas[0].off_cnt[FIELD_W-1:0]))
    else $error("bridge one off count not refreshed");

  refresh_on1_a: assert property (                              // RULE_03
    (quiet_cycle and (meas[0].done && meas[0].on_cnt <= MEAS_W'(FIELD_MAX)))
      |=> on_q[0] == $past(meas[0].on_cnt[FIELD_W-1:0]))
    else $error("bridge one on count not refreshed");

  refresh_on2_a: assert property (                              // RULE_05
    (quiet_cycle and (meas[1].done && meas[1].on_cnt <= MEAS_W'(FIELD_MAX)))
      |=> on_q[1] == $past(meas[1].on_cnt[FIELD_W-1:0]))
    else $error("bridge two on count not refreshed");

  refresh_on3_a: assert property (                              // RULE_07
    (quiet_cycle and (meas[2].done && meas[2].on_cnt <= MEAS_W'(FIELD_MAX)))
      |=> on_q[2] == $past(meas[2].on_cnt[FIELD_W-1:0]))
    else $error("bridge three on count not refreshed");

  refresh_off3_a: assert property (                             // RULE_06
    (quiet_cycle and (meas[2].done && meas[2].off_cnt <= MEAS_W'(FIELD_MAX)))
      |=> off_q[2] == $past(meas[2].off_cnt[FIELD_W-1:0]))
    else $error("bridge three off count not refreshed");

  // Counts above 63 clamp to the field maximum
  sat_on3_a: assert property (                                  // RULE_07
    (quiet_cycle and (meas[2].done && meas[2].on_cnt > MEAS_W'(FIELD_MAX)))
      |=> on_q[2] == FIELD_MAX)
    else $error("bridge three on count not saturated");

  sat_off3_a: assert property (                                 // RULE_06
    (quiet_cycle and (meas[2].done && meas[2].off_cnt > MEAS_W'(FIELD_MAX)))
      |=> off_q[2] == FIELD_MAX)
    else $error("bridge three off count not saturated");

  // Restart drops a measurement that lands during it
  restart_drop_a: assert property (                             // RULE_09
    restart && !soft_rst && meas[2].done |=> $stable(on_q[2]))
    else $error("measurement taken during restart");

  // Soft reset wins over a measurement in the same cycle
  clear_drop_a: assert property (                               // RULE_08
    soft_rst && meas[0].done |=> on_q[0] == FIELD_RESET &&
      off_q[0] == FIELD_RESET)
    else $error("measurement survived soft reset");

  // Without a cause a field never moves
  idle_hold_a: assert property (                                // RULE_11
    (quiet_cycle and !meas[1].done)
      |=> $stable(on_q[1]) && $stable(off_q[1]))
    else $error("bridge two field moved without cause");

endmodule : gate_delay_status_regs

`default_nettype wire

//--- verification/host_model.sv
// Purpose: Host model that issues register reads and writes
// Assumes: Requests launch just after a rising edge of mclk
// Notes:   Address and data lines show the inverse once released
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Host model
// ============================================================
module host_model
  import gate_delay_pkg::*;
(
  // Clock
  input  wire logic              mclk,
  // Requests to the register port
  output var  rd_req_t           rd_req,
  output logic                   wr_stb,
  output logic      [ADDR_W-1:0] wr_addr,
  output logic      [DATA_W-1:0] wr_data,
  // Answers from the register port
  input  wire logic [DATA_W-1:0] rd_data,
  input  wire logic              rd_valid,
  input  wire logic              rd_unmapped,
  input  wire logic              wr_refused
);
  // Idle request lines at time zero
  initial begin
    rd_req  = '0;
    wr_stb  = 1'b0;
    wr_addr = '0;
    wr_data = '0;
  end
  // One read; the answer stands in the cycle after the strobe
  task read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
            output logic v, output logic u);
    @(posedge mclk);
    rd_req <= '{stb: 1'b1, addr: a};
    @(posedge mclk);
    rd_req <= '{stb: 1'b0, addr: ~a};
    #1;
    d = rd_data;
    v = rd_valid;
    u = rd_unmapped;
  endtask : read
  // One write; returns the refusal flag
  task write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w,
             output logic r);
    @(posedge mclk);
    wr_stb  <= 1'b1;
    wr_addr <= a;
    wr_data <= w;
    @(posedge mclk);
    wr_stb  <= 1'b0;
    wr_addr <= ~a;
    wr_data <= ~w;
    #1;
    r = wr_refused;
  endtask : write
endmodule : host_model
`default_nettype wire

//--- verification/testbench.sv
// Purpose: Self-checking bench for the gate delay status registers
// Assumes: Host model drives the register port
// Notes:   Each scenario is one task
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
// ============================================================
// Testbench
// ============================================================
module testbench;
  import gate_delay_pkg::*;
  // Design inputs and outputs
  logic              mclk, rst_n, soft_rst, restart, wr_stb, v, u, r;
  meas_t             meas [NUM_HB];
  rd_req_t           rd_req;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data, rd_data, d;
  logic              rd_valid, rd_unmapped, wr_refused;
  int                fails, num_checks;
  gate_delay_status_regs u_gate_delay_status_regs (.mclk, .rst_n,
    .soft_rst, .restart, .meas, .rd_req, .wr_stb, .wr_addr, .wr_data,
    .rd_data, .rd_valid, .rd_unmapped, .wr_refused);
  host_model u_host_model (.mclk, .rd_req, .wr_stb, .wr_addr, .wr_data,
    .rd_data, .rd_valid, .rd_unmapped, .wr_refused);
  // Clock, 5 ns period
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Verdict and end of run
  task stop_test;
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // Read one register, compare word and flags
  task chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
              input logic un);
    u_host_model.read(a, d, v, u);
    `CHK(v, 1'b1)
    `CHK(u, un)
    `CHK(d, e)
  endtask : chk_rd
  // One finished transition on every bridge, {on, off} each
  task load(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge mclk);
    meas[0] <= {1'b1, a};
    meas[1] <= {1'b1, b};
    meas[2] <= {1'b1, c};
    @(posedge mclk);
    meas[0].done <= 1'b0;
    meas[1].done <= 1'b0;
    meas[2].done <= 1'b0;
  endtask : load
  // Reset values, plus unmapped places on both sides
  task t_reset;
    chk_rd(HB1_DELAYS_ADDR, 16'h0000, 1'b0);
    chk_rd(HB2_DELAYS_ADDR, 16'h0000, 1'b0);
    chk_rd(HB3_DELAYS_ADDR, 16'h0000, 1'b0);
    chk_rd(7'h52, 16'h0000, 1'b1);
    chk_rd(7'h56, 16'h0000, 1'b1);
  endtask : t_reset
  // Field placement, saturation, reserved bits
  task t_fields;
    load(16'h4605, 16'h2A3F, 16'h40FF);
    chk_rd(HB1_DELAYS_ADDR, 16'h053F, 1'b0);
    chk_rd(HB2_DELAYS_ADDR, 16'h3F2A, 1'b0);
    chk_rd(HB3_DELAYS_ADDR, 16'h3F3F, 1'b0);
  endtask : t_fields
  // Writes are refused and change nothing
  task t_write;
    u_host_model.write(HB1_DELAYS_ADDR, 16'hFFFF, r);
    `CHK(r, 1'b1)
    u_host_model.write(HB3_DELAYS_ADDR, 16'h0000, r);
    `CHK(r, 1'b1)
    chk_rd(HB1_DELAYS_ADDR, 16'h053F, 1'b0);
    chk_rd(HB3_DELAYS_ADDR, 16'h3F3F, 1'b0);
  endtask : t_write
  // Restart freezes fields; measurements dropped meanwhile
  task t_restart;
    @(posedge mclk);
    restart <= 1'b1;
    load(16'h0101, 16'h0101, 16'h0101);
    chk_rd(HB2_DELAYS_ADDR, 16'h3F2A, 1'b0);
    @(posedge mclk);
    restart <= 1'b0;
    chk_rd(HB1_DELAYS_ADDR, 16'h053F, 1'b0);
  endtask : t_restart
  // Soft reset with a clashing measurement, then power-on reset
  task t_clear;
    @(posedge mclk);
    soft_rst <= 1'b1;
    meas[0]  <= {1'b1, 16'h0909};
    @(posedge mclk);
    soft_rst     <= 1'b0;
    meas[0].done <= 1'b0;
    chk_rd(HB1_DELAYS_ADDR, 16'h0000, 1'b0);
    chk_rd(HB2_DELAYS_ADDR, 16'h0000, 1'b0);
    load(16'h0202, 16'h0202, 16'h0202);
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
  endtask : t_clear
  // Hang guard
  initial begin
    repeat (3000) @(posedge mclk);
    fails++;
    stop_test();
  end
  // Main sequence
  initial begin
    fails = 0;
    num_checks = 0;
    rst_n = 1'b0;
    soft_rst = 1'b0;
    restart = 1'b0;
    meas = '{default: '0};
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_fields();
    t_write();
    t_restart();
    t_clear();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
